// File: wuc_wakeup_control.sv
// Purpose: wakeup control register with wake flag and mac power modes
// Assumes: aux power good and pci reset are asynchronous pins
// Notes: interrupt status shows wake flag rise and enabled pattern hit events
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module wuc_wakeup_control (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic aux_power_good_in,
  input wire logic aux_power_present_in,
  input wire logic pci_rst_b_in,
  input wire logic pci_33mhz_in,
  input wire logic link_gigabit_in,
  input wire logic eeprom_load_in,
  input wire logic eeprom_assert_adv_in,
  input wire logic cfg_wake_signal_enable_mirror_wr_in,
  input wire logic cfg_wake_signal_enable_mirror_in,
  input wire logic cfg_pme_clr_in,
  input wire logic wake_event_in,
  input wire logic wake_pattern_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic pme_b_out,
  output logic wake_signal_enable_out,
  output logic dyn_powerdown_out,
  output logic smart_powerdown_out,
  output wuc_pkg::wuc_clk_e mac_clk_mode_out,
  output logic irq_out
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pg_sync_r;
  logic [1:0] pr_sync_r;
  logic [1:0] ap_sync_r;
  logic pr_last_r;
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pg_sync_r <= 2'h0;
      pr_sync_r <= 2'h0;
      ap_sync_r <= 2'h0;
      pr_last_r <= 1'b0;
    end
    else
    begin
      pg_sync_r <= {pg_sync_r[0], aux_power_good_in};
      pr_sync_r <= {pr_sync_r[0], pci_rst_b_in};
      ap_sync_r <= {ap_sync_r[0], aux_power_present_in};
      pr_last_r <= pr_sync_r[1];
    end
  end

  // ---------------------------------------------------------------
  // register clear conditions
  // ---------------------------------------------------------------
  // power-good low is a level clear; pci reset release without aux power present is a one-cycle clear
  wire pwr_low = ~pg_sync_r[1];
  wire pci_rise = pr_sync_r[1] & ~pr_last_r & ~ap_sync_r[1];
  wire wipe = pwr_low | pci_rise;

  a_pg_sync_lag: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !aux_power_good_in
    |-> ##2 pwr_low)
    else $error("power good low not seen in time");

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire hit_wuc = reg_addr_in == wuc_pkg::WUC_OFF;
  wire hit_stat = reg_addr_in == wuc_pkg::IRQ_STAT_OFF;
  wire hit_clr = reg_addr_in == wuc_pkg::IRQ_CLR_OFF;
  wire hit_en = reg_addr_in == wuc_pkg::IRQ_EN_OFF;
  wire wr_wuc = reg_wr_in & hit_wuc;
  wire clr_flag_wr = wr_wuc & reg_wdata_in[wuc_pkg::BIT_WAKE_FLAG];

  logic adv_wake_enable_r;
  logic wake_signal_enable_mirror_r;
  logic assert_wake_on_adv_r;
  logic dyn_pd_r;
  logic half_r;
  logic quarter_r;
  logic smart_powerdown_r;

  // ---------------------------------------------------------------
  // wake event flag
  // ---------------------------------------------------------------
  wuc_if wbus ();
  wire adv_hit = wake_pattern_in & adv_wake_enable_r & assert_wake_on_adv_r;
  assign wbus.wake_evt = wake_event_in | adv_hit;
  assign wbus.clr_flag = (clr_flag_wr | cfg_pme_clr_in) & ~wipe;
  wire flag_clr_b = rst_b_in;
  logic wake_event_flag;
  logic flag_wiped_r;
  wuc_pme_flag u_flag (
    .sys_clk_in(sys_clk_in),
    .clr_b_in(flag_clr_b),
    .bus(wbus)
  );
  // wipe masks the flag since the helper's clear is the async reset only
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      flag_wiped_r <= 1'b1;
    else if (wipe)
      flag_wiped_r <= 1'b1;
    else if (wbus.wake_evt)
      flag_wiped_r <= 1'b0;
  end
  assign wake_event_flag = wbus.flag & ~flag_wiped_r;

  a_cfg_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cfg_pme_clr_in & ~wbus.wake_evt)
    |=> !wake_event_flag)
    else $error("config clear left the flag set");
  a_zero_keeps: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wake_event_flag & wr_wuc & !clr_flag_wr & !cfg_pme_clr_in & !wipe)
    |=> wake_event_flag)
    else $error("zero write disturbed the flag");
  a_adv_gated: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wake_pattern_in & !adv_wake_enable_r & !wake_event_in & !wake_event_flag)
    |=> !wake_event_flag)
    else $error("pattern acted with wakeup disabled");

  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      adv_wake_enable_r <= 1'b0;
      wake_signal_enable_mirror_r <= 1'b0;
      assert_wake_on_adv_r <= 1'b0;
      dyn_pd_r <= 1'b0;
      half_r <= 1'b0;
      quarter_r <= 1'b0;
      smart_powerdown_r <= 1'b0;
    end
    else if (wipe)
    begin
      adv_wake_enable_r <= 1'b0;
      wake_signal_enable_mirror_r <= 1'b0;
      assert_wake_on_adv_r <= 1'b0;
      dyn_pd_r <= 1'b0;
      half_r <= 1'b0;
      quarter_r <= 1'b0;
      smart_powerdown_r <= 1'b0;
    end
    else
    begin
      if (eeprom_load_in)
        assert_wake_on_adv_r <= eeprom_assert_adv_in;
      else if (wr_wuc)
        assert_wake_on_adv_r <= reg_wdata_in[wuc_pkg::BIT_ASSERT_ADV];
      if (wr_wuc)
      begin
        adv_wake_enable_r <= reg_wdata_in[wuc_pkg::BIT_ADV_WAKE];
        wake_signal_enable_mirror_r <= reg_wdata_in[wuc_pkg::BIT_WAKE_SIGNAL_ENABLE_MIRROR];
        dyn_pd_r <= reg_wdata_in[wuc_pkg::BIT_DYN_PD];
        half_r <= reg_wdata_in[wuc_pkg::BIT_HALF];
        quarter_r <= reg_wdata_in[wuc_pkg::BIT_QUARTER];
        smart_powerdown_r <= reg_wdata_in[wuc_pkg::BIT_SMART_PD];
      end
      else if (cfg_wake_signal_enable_mirror_wr_in)
        wake_signal_enable_mirror_r <= cfg_wake_signal_enable_mirror_in;
    end
  end

  a_adv_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wr_wuc & !wipe)
    |=> (adv_wake_enable_r == $past(reg_wdata_in[wuc_pkg::BIT_ADV_WAKE])))
    else $error("advanced wakeup enable not written");
  a_mirror_reg: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wr_wuc & !wipe)
    |=> (wake_signal_enable_out == $past(reg_wdata_in[wuc_pkg::BIT_WAKE_SIGNAL_ENABLE_MIRROR])))
    else $error("pme enable copy not written");
  a_mirror_cfg: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cfg_wake_signal_enable_mirror_wr_in & !wr_wuc & !wipe)
    |=> (wake_signal_enable_out == $past(cfg_wake_signal_enable_mirror_in)))
    else $error("pme enable copy missed config write");
  a_eeprom_load: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (eeprom_load_in & !wipe)
    |=> (assert_wake_on_adv_r == $past(eeprom_assert_adv_in)))
    else $error("eeprom value not loaded");
  a_dyn_pd: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wr_wuc & !wipe)
    |=> (dyn_powerdown_out == $past(reg_wdata_in[wuc_pkg::BIT_DYN_PD])))
    else $error("dynamic powerdown not written");
  a_bits_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!wr_wuc & !wipe & !eeprom_load_in & !cfg_wake_signal_enable_mirror_wr_in)
    |=> $stable({smart_powerdown_r, quarter_r, half_r, dyn_pd_r, assert_wake_on_adv_r,
                 wake_signal_enable_mirror_r, adv_wake_enable_r}))
    else $error("control bits moved without a write");

  // ---------------------------------------------------------------
  // interrupt status: bit0 wake flag rise, bit1 pattern hit with pme enable set
  // ---------------------------------------------------------------
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  logic flag_last_r;
  wire [1:0] irq_evt = {adv_hit & wake_signal_enable_mirror_r, wake_event_flag & ~flag_last_r};
  wire [1:0] irq_clr = (reg_wr_in & hit_clr) ? reg_wdata_in[1:0] : 2'h0;
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_stat_r <= wuc_pkg::IRQ_RESET;
      irq_en_r <= wuc_pkg::IRQ_RESET;
      flag_last_r <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_evt | (irq_stat_r & ~irq_clr);
      flag_last_r <= wake_event_flag;
      if (reg_wr_in & hit_en)
        irq_en_r <= reg_wdata_in[1:0];
    end
  end
  assign irq_out = |(irq_stat_r & irq_en_r);

  a_irq_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (irq_stat_r[0] & !irq_clr[0])
    |=> irq_stat_r[0])
    else $error("wake status bit dropped on its own");
  a_irq_pattern: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (adv_hit & wake_signal_enable_mirror_r)
    |=> irq_stat_r[1])
    else $error("pattern status bit not set");

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [31:0] wuc_view = {smart_powerdown_r, quarter_r, half_r, dyn_pd_r, 24'h00_0000,
                          assert_wake_on_adv_r, wake_event_flag,
                          wake_signal_enable_mirror_r, adv_wake_enable_r};
  wire [31:0] rd_mux = hit_wuc ? wuc_view :
                       hit_stat ? {30'h0, irq_stat_r} :
                       hit_en ? {30'h0, irq_en_r} : 32'h0000_0000;
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
      reg_rdata_out <= rd_mux;
    else
      reg_rdata_out <= 32'h0000_0000;
  end
  a_wuc_readback: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ($past(reg_rd_in) & $past(hit_wuc))
    |-> (reg_rdata_out == $past(wuc_view)))
    else $error("read data differ from register");

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // pme held while flag and enable both set, as the pci pin expects
  logic pme_b_r;
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pme_b_r <= 1'b1;
    else
      pme_b_r <= ~(wake_event_flag & wake_signal_enable_mirror_r);
  end
  assign pme_b_out = pme_b_r;
  assign wake_signal_enable_out = wake_signal_enable_mirror_r;
  assign dyn_powerdown_out = dyn_pd_r;
  assign smart_powerdown_out = smart_powerdown_r;
  always_comb
  begin
    if (link_gigabit_in & half_r & pci_33mhz_in)
      mac_clk_mode_out = wuc_pkg::WUC_MAC_HALF;
    else if (~link_gigabit_in & quarter_r)
      mac_clk_mode_out = wuc_pkg::WUC_MAC_QUARTER;
    else if (~half_r & ~quarter_r)
      mac_clk_mode_out = wuc_pkg::WUC_MAC_SEL;
    else
      mac_clk_mode_out = wuc_pkg::WUC_MAC_FULL;
  end

  a_pme_release: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !(wake_event_flag & wake_signal_enable_mirror_r)
    |=> pme_b_out)
    else $error("pme held without cause");
  a_quarter_mode: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (quarter_r & !link_gigabit_in)
    |-> (mac_clk_mode_out == wuc_pkg::WUC_MAC_QUARTER))
    else $error("quarter speed missing");
  a_sel_mode: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!half_r & !quarter_r)
    |-> (mac_clk_mode_out == wuc_pkg::WUC_MAC_SEL))
    else $error("frequency select not in charge");
  a_full_gig: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (link_gigabit_in & half_r & !pci_33mhz_in)
    |-> (mac_clk_mode_out == wuc_pkg::WUC_MAC_FULL))
    else $error("half speed without 33 MHz bus");

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_wipe_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    pwr_low
    |=> (wuc_view == wuc_pkg::WUC_RESET))
    else $error("register not cleared");
  a_pci_wipe: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    pci_rise
    |=> (wuc_view == wuc_pkg::WUC_RESET))
    else $error("pci reset rise did not clear");
  a_adv_pme: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (adv_hit & ~wipe)
    |=> wake_event_flag)
    else $error("pattern did not set flag");
  a_flag_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (clr_flag_wr & ~wbus.wake_evt & ~wipe)
    |=> ~wake_event_flag)
    else $error("flag not cleared");
  a_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $past(reg_rd_in)
    |-> (reg_rdata_out[27:4] == 24'h0))
    else $error("reserved nonzero");
  a_event_sets: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wake_event_in & ~wipe)
    |=> wake_event_flag)
    else $error("event lost");
  a_pme_pin: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wake_event_flag & wake_signal_enable_mirror_r)
    |=> ~pme_b_out)
    else $error("pme not asserted");
  a_smart_pd: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wr_wuc & ~wipe)
    |=> (smart_powerdown_out == $past(reg_wdata_in[31])))
    else $error("smart powerdown wrong");
  a_half_mode: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (half_r & link_gigabit_in & pci_33mhz_in)
    |-> (mac_clk_mode_out == wuc_pkg::WUC_MAC_HALF))
    else $error("half speed missing");
endmodule // wuc_wakeup_control
`default_nettype wire

// File: wuc_pkg.sv
// Purpose: constants for the wakeup control block
// Assumes: 32-bit register port, byte offsets
// Notes: none
package wuc_pkg;
  localparam logic [15:0] WUC_OFF = 16'h5800;
  localparam logic [15:0] IRQ_STAT_OFF = 16'h5804;
  localparam logic [15:0] IRQ_CLR_OFF = 16'h580c;
  localparam logic [15:0] IRQ_EN_OFF = 16'h5814;
  localparam int BIT_ADV_WAKE = 0;
  localparam int BIT_WAKE_SIGNAL_ENABLE_MIRROR = 1;
  localparam int BIT_WAKE_FLAG = 2;
  localparam int BIT_ASSERT_ADV = 3;
  localparam int BIT_DYN_PD = 28;
  localparam int BIT_HALF = 29;
  localparam int BIT_QUARTER = 30;
  localparam int BIT_SMART_PD = 31;
  localparam logic [31:0] WUC_RW_MASK = 32'hf000_000b;
  localparam logic [31:0] WUC_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  typedef enum logic [1:0] {WUC_MAC_FULL, WUC_MAC_HALF, WUC_MAC_QUARTER, WUC_MAC_SEL} wuc_clk_e;
endpackage

// File: wuc_if.sv
// Purpose: carries the wake event request into the pme helper
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface wuc_if;
  logic wake_evt;
  logic clr_flag;
  logic flag;
  modport ctl (output wake_evt, output clr_flag, input flag);
  modport pme (input wake_evt, input clr_flag, output flag);
endinterface
`default_nettype wire

// File: wuc_pme_flag.sv
// Purpose: sticky wake event flag, shared with the power management status
// Assumes: set and clear are one-cycle pulses
// Notes: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module wuc_pme_flag (
  input wire logic sys_clk_in,
  input wire logic clr_b_in,
  wuc_if.pme bus
);
  logic flag_r;
  logic flag_nxt;
  assign flag_nxt = bus.wake_evt | (flag_r & ~bus.clr_flag);
  always_ff @(posedge sys_clk_in or negedge clr_b_in)
  begin
    if (!clr_b_in)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end
  assign bus.flag = flag_r;
endmodule // wuc_pme_flag
`default_nettype wire

// File: wuc_pm_host.sv
// Purpose: host power management side, drives config space pulses
// Assumes: bench requests are one-cycle pulses
// Notes: seen flag mimics the host status latch of the wake line
`timescale 1ns/1ps
`default_nettype none
module wuc_pm_host (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic en_req_in,
  input wire logic en_val_in,
  input wire logic clr_req_in,
  input wire logic pme_b_in,
  output logic cfg_wake_signal_enable_mirror_wr_out,
  output logic cfg_wake_signal_enable_mirror_out,
  output logic cfg_pme_clr_out,
  output logic pme_seen_out
);
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      cfg_wake_signal_enable_mirror_wr_out <= 1'b0;
      cfg_wake_signal_enable_mirror_out <= 1'b0;
      cfg_pme_clr_out <= 1'b0;
      pme_seen_out <= 1'b0;
    end
    else
    begin
      cfg_wake_signal_enable_mirror_wr_out <= en_req_in;
      // data only meaningful with the write pulse
      cfg_wake_signal_enable_mirror_out <= en_req_in ? en_val_in : ~cfg_wake_signal_enable_mirror_out;
      cfg_pme_clr_out <= clr_req_in;
      pme_seen_out <= clr_req_in ? 1'b0 : (pme_seen_out | ~pme_b_in);
    end
endmodule // wuc_pm_host
`default_nettype wire

// File: test_wuc_wakeup_control.sv
// Purpose: self-checking bench for the wakeup control block
// Assumes: register port answers in one cycle
// Notes: expected register image kept in m, irq status in st
`timescale 1ns/1ps
`default_nettype none
module test_wuc_wakeup_control;
  logic clk, rst_b, apg, apres, prst_b, p33, gig, eev, env, wr, rd, pme_b, wse, dpd, spd, irq;
  logic cw, ce, cc, seen;
  logic [4:0] ev;
  logic [15:0] addr;
  logic [31:0] wd, rdata, m, d, q;
  logic [1:0] st, ien;
  wuc_pkg::wuc_clk_e mode;
  int errors, check_count;
  wuc_pm_host u_host (.sys_clk_in(clk), .rst_b_in(rst_b), .en_req_in(ev[1]), .en_val_in(env),
    .clr_req_in(ev[2]), .pme_b_in(pme_b), .cfg_wake_signal_enable_mirror_wr_out(cw), .cfg_wake_signal_enable_mirror_out(ce),
    .cfg_pme_clr_out(cc), .pme_seen_out(seen));
  wuc_wakeup_control u_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .aux_power_good_in(apg),
    .aux_power_present_in(apres), .pci_rst_b_in(prst_b), .pci_33mhz_in(p33),
    .link_gigabit_in(gig), .eeprom_load_in(ev[0]), .eeprom_assert_adv_in(eev),
    .cfg_wake_signal_enable_mirror_wr_in(cw), .cfg_wake_signal_enable_mirror_in(ce), .cfg_pme_clr_in(cc), .wake_event_in(ev[3]),
    .wake_pattern_in(ev[4]), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .pme_b_out(pme_b), .wake_signal_enable_out(wse),
    .dyn_powerdown_out(dpd), .smart_powerdown_out(spd), .mac_clk_mode_out(mode), .irq_out(irq));
  // ------------------------------------
  // tasks
  // ------------------------------------
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    check_count++;
    if (seen_v !== exp_v)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr32(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd32(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  function automatic wuc_pkg::wuc_clk_e mode_exp(input logic [31:0] v);
    if (!v[29] && !v[30])
      return wuc_pkg::WUC_MAC_SEL;
    if (gig)
      return (v[29] && p33) ? wuc_pkg::WUC_MAC_HALF : wuc_pkg::WUC_MAC_FULL;
    return v[30] ? wuc_pkg::WUC_MAC_QUARTER : wuc_pkg::WUC_MAC_FULL;
  endfunction
  task automatic verify;
    rd32(wuc_pkg::WUC_OFF, q);
    check(q, m);
    check({27'h0, pme_b, wse, dpd, spd, irq},
      {27'h0, !(m[2] && m[1]), m[1], m[28], m[31], (st & ien) != 2'h0});
    check({30'h0, mode}, {30'h0, mode_exp(m)});
    // realign to an edge so the caller drives inputs on it
    @(posedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done();
  end
  initial
  begin
    {rst_b, p33, gig, eev, env, wr, rd, ev, addr, wd} = '0;
    {apg, apres, prst_b} = 3'h7;
    {errors, check_count, m, st, ien} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    void'($urandom(54515));
    verify();
    eev <= 1'b1;
    pulse(0);
    m[3] = 1'b1;
    verify();
    $display("test reset and load done");
    repeat (24)
    begin
      d = $urandom;
      gig <= 1'($urandom);
      p33 <= 1'($urandom);
      wr32(wuc_pkg::WUC_OFF, d);
      // bit 2 only ever cleared by a one
      m = (d & wuc_pkg::WUC_RW_MASK) | (m & ~d & 32'h4);
      verify();
    end
    $display("test random writes done");
    wr32(wuc_pkg::IRQ_EN_OFF, 32'h1);
    ien = 2'h1;
    wr32(wuc_pkg::WUC_OFF, 32'h2);
    m = 32'h2;
    pulse(3);
    m = 32'h6;
    st = 2'h1;
    verify();
    check({31'h0, seen}, 32'h1);
    wr32(wuc_pkg::WUC_OFF, 32'h2);
    verify();
    wr32(wuc_pkg::WUC_OFF, 32'h6);
    m = 32'h2;
    verify();
    wr32(wuc_pkg::IRQ_EN_OFF, 32'h0);
    ien = 2'h0;
    verify();
    wr32(wuc_pkg::IRQ_CLR_OFF, 32'h3);
    wr32(wuc_pkg::IRQ_EN_OFF, 32'h1);
    {st, ien} = 4'h1;
    rd32(wuc_pkg::IRQ_STAT_OFF, q);
    check(q, {30'h0, st});
    rd32(wuc_pkg::IRQ_EN_OFF, q);
    check(q, {30'h0, ien});
    rd32(16'h5900, q);
    check(q, 32'h0);
    $display("test wake flag and irq done");
    for (int i = 0; i < 3; i++)
    begin
      wr32(wuc_pkg::WUC_OFF, i == 0 ? 32'h2 : (i == 1 ? 32'ha : 32'hb));
      m = i == 0 ? 32'h2 : (i == 1 ? 32'ha : 32'hb);
      pulse(4);
      m[2] = (i == 2);
      st = (i == 2) ? 2'h3 : 2'h0;
      verify();
    end
    rd32(wuc_pkg::IRQ_STAT_OFF, q);
    check(q, {30'h0, st});
    pulse(2);
    m[2] = 1'b0;
    verify();
    env <= 1'b0;
    pulse(1);
    m[1] = 1'b0;
    verify();
    $display("test pattern and config done");
    wr32(wuc_pkg::IRQ_EN_OFF, 32'h0);
    ien = 2'h0;
    for (int k = 0; k < 3; k++)
    begin
      wr32(wuc_pkg::WUC_OFF, 32'hf000000b);
      m = 32'hf000000b;
      apres <= (k != 1);
      apg <= (k != 2);
      prst_b <= (k == 2);
      repeat (4) @(posedge clk);
      {apg, prst_b} <= 2'h3;
      repeat (4) @(posedge clk);
      if (k != 0)
        m = 32'h0;
      verify();
    end
    $display("test power wipe done");
    test_done();
  end
endmodule // test_wuc_wakeup_control
`default_nettype wire
